// File: core/hmr_pkg.sv
/*
 * Shared constants and types for the headphone monitor router.
 * Assumes a 40 MHz core clock and a 32-bit AHB-Lite register bus.
 */
package hmr_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned HOLD_MS = 1000;
    localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned BLINK_MS = 125;
    localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W = 26;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int unsigned N_CH = 5;
    localparam int unsigned N_SW = 7;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam int unsigned CTRL_SEL_LSB = 0;
    localparam int unsigned CTRL_TC_BIT = 3;
    localparam logic [2:0] CTRL_SEL_RST = 3'h0;
    localparam logic CTRL_TC_RST = 1'b0;
    localparam int unsigned STAT_SOLO_LSB = 0;
    localparam int unsigned STAT_RTN_LSB = 5;
    localparam int unsigned STAT_SPLIT_LSB = 7;
    localparam int unsigned STAT_LOOP_LSB = 9;

    // ----------------------------------------
    // headphone selector positions
    // ----------------------------------------
    localparam logic [2:0] SEL_ST = 3'h0;
    localparam logic [2:0] SEL_MONO = 3'h1;
    localparam logic [2:0] SEL_LEFT = 3'h2;
    localparam logic [2:0] SEL_RIGHT = 3'h3;
    localparam logic [2:0] SEL_MID_SIDE = 3'h4;
    localparam logic [2:0] SEL_REC = 3'h5;

    // ----------------------------------------
    // earpiece source codes
    // ----------------------------------------
    localparam logic [3:0] SRC_PGM_L = 4'h0;
    localparam logic [3:0] SRC_PGM_R = 4'h1;
    localparam logic [3:0] SRC_PGM_MONO = 4'h2;
    localparam logic [3:0] SRC_MS_L = 4'h3;
    localparam logic [3:0] SRC_MS_R = 4'h4;
    localparam logic [3:0] SRC_REC_L = 4'h5;
    localparam logic [3:0] SRC_REC_R = 4'h6;
    localparam logic [3:0] SRC_RTNA_L = 4'h7;
    localparam logic [3:0] SRC_RTNA_R = 4'h8;
    localparam logic [3:0] SRC_RTNB_L = 4'h9;
    localparam logic [3:0] SRC_RTNB_R = 4'ha;
    localparam logic [3:0] SRC_RTNA_MONO = 4'hb;
    localparam logic [3:0] SRC_RTNB_MONO = 4'hc;
    localparam logic [3:0] SRC_SOLO = 4'hd;

    // ----------------------------------------
    // tape / mono output sources and gain targets
    // ----------------------------------------
    localparam logic [1:0] TAPE_BUS = 2'h0;
    localparam logic [1:0] TAPE_RTNA = 2'h1;
    localparam logic [1:0] TAPE_RTNB = 2'h2;
    localparam logic [1:0] GAIN_HP = 2'h0;
    localparam logic [1:0] GAIN_RTNA = 2'h1;
    localparam logic [1:0] GAIN_RTNB = 2'h2;

    typedef enum logic [1:0] {SPLIT_OFF, SPLIT_A, SPLIT_B, SPLIT_AB} hmr_split_t;
    typedef enum logic [1:0] {LOOP_OFF, LOOP_A, LOOP_B} hmr_loop_t;

endpackage : hmr_pkg

// File: core/hmr_gesture.sv
/*
 * Slide switch gesture decoder: short slide gives a tap on release,
 * a hold past the threshold gives a momentary level while held.
 * Assumes a debounced switch level synchronous to the clock.
 */
`timescale 1ns/1ps
module hmr_gesture #(
    parameter logic [25:0] P_HOLD_CYC = 26'(hmr_pkg::HOLD_CYC)
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_held,
    output logic o_press,
    output logic o_tap,
    output logic o_mom
);
    typedef struct packed {
        logic prev;
        logic long_hold;
        logic [25:0] cnt;
        logic press;
        logic tap;
        logic mom;
    } hmr_gest_t;

    hmr_gest_t s_r;
    hmr_gest_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.prev = i_held;
        s_nxt.press = i_held & ~s_r.prev;
        s_nxt.tap = ~i_held & s_r.prev & ~s_r.long_hold;
        if (i_held && !s_r.prev) begin
            s_nxt.cnt = 26'h0;
            s_nxt.long_hold = 1'b0;
        end else if (i_held && !s_r.long_hold) begin
            if (s_r.cnt == P_HOLD_CYC - 26'h1) begin
                s_nxt.long_hold = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 26'h1;
            end
        end
        s_nxt.mom = i_held & s_nxt.long_hold;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_press = s_r.press;
    assign o_tap = s_r.tap;
    assign o_mom = s_r.mom;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    AST_TAP_NOT_AFTER_HOLD: assert property (s_r.mom ##1 !s_r.prev |-> !o_tap)
        else $error("tap after a long hold");
    AST_MOM_NEEDS_HOLD: assert property ($rose(o_mom) |-> $past(i_held, 2))
        else $error("momentary without a hold");
endmodule : hmr_gesture

// File: core/hmr_blink.sv
/*
 * Indicator pattern generator: steady flash and two-pulse sequence.
 * Assumes a free running core clock; one phase step every P_BLINK_CYC cycles.
 */
`timescale 1ns/1ps
module hmr_blink #(
    parameter logic [25:0] P_BLINK_CYC = 26'(hmr_pkg::BLINK_CYC)
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    output logic o_flash,
    output logic o_double
);
    typedef struct packed {
        logic [25:0] div;
        logic [2:0] phase;
        logic flash;
        logic double;
    } hmr_blink_t;

    hmr_blink_t s_r;
    hmr_blink_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (s_r.div == P_BLINK_CYC - 26'h1) begin
            s_nxt.div = 26'h0;
            s_nxt.phase = s_r.phase + 3'h1;
        end else begin
            s_nxt.div = s_r.div + 26'h1;
        end
        s_nxt.flash = ~s_nxt.phase[2];
        s_nxt.double = (s_nxt.phase == 3'h0) | (s_nxt.phase == 3'h2);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_flash = s_r.flash;
    assign o_double = s_r.double;
endmodule : hmr_blink

// File: core/hmr_top.sv
/*
 * Headphone monitor router: solo, returns, split ear, loopback, LEDs,
 * with an AHB-Lite slave for selector and time code control.
 * Assumes debounced switch levels and one-cycle knob step pulses.
 */
`timescale 1ns/1ps
module hmr_top #(
    parameter logic [25:0] P_HOLD_CYC = 26'(hmr_pkg::HOLD_CYC),
    parameter logic [25:0] P_BLINK_CYC = 26'(hmr_pkg::BLINK_CYC)
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic [4:0] i_solo_sw,
    input wire logic i_rtn_sw_a,
    input wire logic i_rtn_sw_b,
    input wire logic i_knob_hold,
    input wire logic i_knob_step,
    input wire logic i_knob_up,
    input wire logic i_modifier_key,
    input wire logic [1:0] i_rtn_active,
    input wire logic [1:0] i_rtn_clip,
    output logic [3:0] o_hp_l_src,
    output logic [3:0] o_hp_r_src,
    output logic [4:0] o_solo_mask,
    output logic [2:0] o_meter_left_sel,
    output logic [1:0] o_tape_src,
    output logic [4:0] o_ch_led_yellow,
    output logic [1:0] o_rtn_led_green,
    output logic [1:0] o_rtn_led_red,
    output logic [1:0] o_rtn_led_yellow,
    output logic [1:0] o_gain_sel,
    output logic o_gain_step,
    output logic o_gain_up
);
    typedef struct packed {
        logic [2:0] hp_sel;
        logic tc_en;
        logic [4:0] sol_lat;
        logic [1:0] rtn_lat;
        logic [1:0] cons;
        logic a_in_hold;
        hmr_pkg::hmr_split_t split;
        hmr_pkg::hmr_loop_t loop;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
        logic hready;
        logic [3:0] hp_l;
        logic [3:0] hp_r;
        logic [4:0] solo_mask;
        logic [2:0] meter;
        logic [1:0] tape;
        logic [4:0] ch_y;
        logic [1:0] rtn_g;
        logic [1:0] rtn_r;
        logic [1:0] rtn_y;
        logic [1:0] gain_sel;
        logic gain_step;
        logic gain_up;
    } hmr_state_t;

    hmr_state_t st_r;
    hmr_state_t st_nxt;
    logic [6:0] g_press;
    logic [6:0] g_tap;
    logic [6:0] g_mom;
    logic [6:0] sw;
    logic flash;
    logic double;
    logic [1:0] rtn_mom;
    logic [1:0] rtn_on;
    logic [4:0] solo_now;

    // ----------------------------------------
    // switch gestures and indicator patterns
    // ----------------------------------------
    assign sw = {i_rtn_sw_b, i_rtn_sw_a, i_solo_sw};

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_sw
            hmr_gesture #(.P_HOLD_CYC(P_HOLD_CYC)) u_gest (
                .i_core_clk(i_core_clk),
                .i_rst(i_rst),
                .i_held(sw[gi]),
                .o_press(g_press[gi]),
                .o_tap(g_tap[gi]),
                .o_mom(g_mom[gi])
            );
        end
    endgenerate

    hmr_blink #(.P_BLINK_CYC(P_BLINK_CYC)) u_blink (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .o_flash(flash),
        .o_double(double)
    );

    // gestures taken by knob or modifier do not latch or hold a return
    assign rtn_mom = g_mom[6:5] & ~st_r.cons;
    assign rtn_on = {(st_r.rtn_lat[1] | rtn_mom[1]) & ~st_r.tc_en,
                     st_r.rtn_lat[0] | rtn_mom[0]};
    assign solo_now = st_r.sol_lat | g_mom[4:0];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic ap;
        logic spc;
        ap = i_hsel & i_htrans[1] & i_hready;
        spc = i_knob_hold | i_modifier_key;
        st_nxt = st_r;

        // bus slave, zero wait states, always OKAY
        st_nxt.hready = 1'b1;
        st_nxt.dp_wr = ap & i_hwrite;
        st_nxt.dp_addr = i_haddr[7:0];
        if (st_r.dp_wr && st_r.dp_addr == hmr_pkg::ADDR_CTRL) begin
            st_nxt.hp_sel = i_hwdata[hmr_pkg::CTRL_SEL_LSB +: 3];
            st_nxt.tc_en = i_hwdata[hmr_pkg::CTRL_TC_BIT];
        end
        if (ap && !i_hwrite) begin
            st_nxt.hrdata = 32'h0;
            if (i_haddr[7:0] == hmr_pkg::ADDR_CTRL) begin
                st_nxt.hrdata[hmr_pkg::CTRL_SEL_LSB +: 3] = st_r.hp_sel;
                st_nxt.hrdata[hmr_pkg::CTRL_TC_BIT] = st_r.tc_en;
            end else if (i_haddr[7:0] == hmr_pkg::ADDR_STAT) begin
                st_nxt.hrdata[hmr_pkg::STAT_SOLO_LSB +: 5] = st_r.sol_lat;
                st_nxt.hrdata[hmr_pkg::STAT_RTN_LSB +: 2] = st_r.rtn_lat;
                st_nxt.hrdata[hmr_pkg::STAT_SPLIT_LSB +: 2] = st_r.split;
                st_nxt.hrdata[hmr_pkg::STAT_LOOP_LSB +: 2] = st_r.loop;
            end
        end

        // channel solo latches
        for (int i = 0; i < 5; i++) begin
            if (g_tap[i]) begin
                st_nxt.sol_lat = st_r.sol_lat[i] ? 5'h00 : (5'h01 << i);
            end
        end

        // return switch gestures
        if (!i_knob_hold) begin
            st_nxt.a_in_hold = 1'b0;
        end
        for (int k = 0; k < 2; k++) begin
            if (g_press[5 + k]) begin
                st_nxt.cons[k] = spc;
            end
            if (g_tap[5 + k] && !st_r.cons[k] && !(k == 1 && st_r.tc_en)) begin
                st_nxt.rtn_lat[k] = ~st_r.rtn_lat[k];
            end
        end
        if (g_press[5] && i_knob_hold) begin
            st_nxt.a_in_hold = 1'b1;
            if (st_r.split == hmr_pkg::SPLIT_A || st_r.split == hmr_pkg::SPLIT_AB) begin
                st_nxt.split = hmr_pkg::SPLIT_OFF;
            end else begin
                st_nxt.split = hmr_pkg::SPLIT_A;
            end
        end else if (g_press[6] && i_knob_hold) begin
            if (st_r.a_in_hold && st_r.split == hmr_pkg::SPLIT_A) begin
                st_nxt.split = hmr_pkg::SPLIT_AB;
            end else if (st_r.split == hmr_pkg::SPLIT_B) begin
                st_nxt.split = hmr_pkg::SPLIT_OFF;
            end else begin
                st_nxt.split = hmr_pkg::SPLIT_B;
            end
        end else if (g_press[5] && i_modifier_key) begin
            st_nxt.loop = (st_r.loop == hmr_pkg::LOOP_A) ? hmr_pkg::LOOP_OFF
                                                         : hmr_pkg::LOOP_A;
        end else if (g_press[6] && i_modifier_key && !st_r.tc_en) begin
            st_nxt.loop = (st_r.loop == hmr_pkg::LOOP_B) ? hmr_pkg::LOOP_OFF
                                                         : hmr_pkg::LOOP_B;
        end

        // headphone routing; main outputs are not driven here at all
        st_nxt.solo_mask = solo_now;
        if (rtn_on[0]) begin
            st_nxt.hp_l = hmr_pkg::SRC_RTNA_L;
            st_nxt.hp_r = hmr_pkg::SRC_RTNA_R;
        end else if (rtn_on[1]) begin
            st_nxt.hp_l = hmr_pkg::SRC_RTNB_L;
            st_nxt.hp_r = hmr_pkg::SRC_RTNB_R;
        end else if (st_r.split == hmr_pkg::SPLIT_A) begin
            st_nxt.hp_l = hmr_pkg::SRC_RTNA_MONO;
            st_nxt.hp_r = hmr_pkg::SRC_PGM_R;
        end else if (st_r.split == hmr_pkg::SPLIT_B) begin
            st_nxt.hp_l = hmr_pkg::SRC_PGM_L;
            st_nxt.hp_r = st_r.tc_en ? hmr_pkg::SRC_PGM_R : hmr_pkg::SRC_RTNB_MONO;
        end else if (st_r.split == hmr_pkg::SPLIT_AB) begin
            st_nxt.hp_l = hmr_pkg::SRC_RTNA_MONO;
            st_nxt.hp_r = st_r.tc_en ? hmr_pkg::SRC_PGM_R : hmr_pkg::SRC_RTNB_MONO;
        end else if (solo_now != 5'h00) begin
            st_nxt.hp_l = hmr_pkg::SRC_SOLO;
            st_nxt.hp_r = hmr_pkg::SRC_SOLO;
        end else begin
            case (st_r.hp_sel)
                hmr_pkg::SEL_MONO: begin
                    st_nxt.hp_l = hmr_pkg::SRC_PGM_MONO;
                    st_nxt.hp_r = hmr_pkg::SRC_PGM_MONO;
                end
                hmr_pkg::SEL_LEFT: begin
                    st_nxt.hp_l = hmr_pkg::SRC_PGM_L;
                    st_nxt.hp_r = hmr_pkg::SRC_PGM_L;
                end
                hmr_pkg::SEL_RIGHT: begin
                    st_nxt.hp_l = hmr_pkg::SRC_PGM_R;
                    st_nxt.hp_r = hmr_pkg::SRC_PGM_R;
                end
                hmr_pkg::SEL_MID_SIDE: begin
                    st_nxt.hp_l = hmr_pkg::SRC_MS_L;
                    st_nxt.hp_r = hmr_pkg::SRC_MS_R;
                end
                hmr_pkg::SEL_REC: begin
                    st_nxt.hp_l = hmr_pkg::SRC_REC_L;
                    st_nxt.hp_r = hmr_pkg::SRC_REC_R;
                end
                default: begin
                    st_nxt.hp_l = hmr_pkg::SRC_PGM_L;
                    st_nxt.hp_r = hmr_pkg::SRC_PGM_R;
                end
            endcase
        end

        // left meter follows the lowest soloed channel
        st_nxt.meter = 3'h0;
        for (int i = 4; i >= 0; i--) begin
            if (solo_now[i]) begin
                st_nxt.meter = 3'(i + 1);
            end
        end

        // tape and mono mic output source
        if (st_r.loop == hmr_pkg::LOOP_A) begin
            st_nxt.tape = hmr_pkg::TAPE_RTNA;
        end else if (st_r.loop == hmr_pkg::LOOP_B && !st_r.tc_en) begin
            st_nxt.tape = hmr_pkg::TAPE_RTNB;
        end else begin
            st_nxt.tape = hmr_pkg::TAPE_BUS;
        end

        // indicators
        st_nxt.ch_y = st_r.sol_lat & {5{flash}};
        st_nxt.rtn_r = i_rtn_clip;
        st_nxt.rtn_g = i_rtn_active & ~i_rtn_clip;
        for (int k = 0; k < 2; k++) begin
            if (st_r.split == hmr_pkg::SPLIT_AB) begin
                st_nxt.rtn_y[k] = 1'b1;
            end else if (st_r.split == (k == 0 ? hmr_pkg::SPLIT_A : hmr_pkg::SPLIT_B)) begin
                st_nxt.rtn_y[k] = double;
            end else if (st_r.loop == (k == 0 ? hmr_pkg::LOOP_A : hmr_pkg::LOOP_B)) begin
                st_nxt.rtn_y[k] = flash;
            end else begin
                st_nxt.rtn_y[k] = st_r.rtn_lat[k];
            end
        end

        // monitor knob target
        if (i_rtn_sw_a && !st_r.cons[0]) begin
            st_nxt.gain_sel = hmr_pkg::GAIN_RTNA;
        end else if (i_rtn_sw_b && !st_r.cons[1]) begin
            st_nxt.gain_sel = hmr_pkg::GAIN_RTNB;
        end else begin
            st_nxt.gain_sel = hmr_pkg::GAIN_HP;
        end
        st_nxt.gain_step = i_knob_step;
        st_nxt.gain_up = i_knob_up;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_r <= '0;
            st_r.hp_sel <= hmr_pkg::CTRL_SEL_RST;
            st_r.tc_en <= hmr_pkg::CTRL_TC_RST;
            st_r.split <= hmr_pkg::SPLIT_OFF;
            st_r.loop <= hmr_pkg::LOOP_OFF;
            st_r.hready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_hrdata = st_r.hrdata;
    assign o_hreadyout = st_r.hready;
    assign o_hresp = 1'b0;
    assign o_hp_l_src = st_r.hp_l;
    assign o_hp_r_src = st_r.hp_r;
    assign o_solo_mask = st_r.solo_mask;
    assign o_meter_left_sel = st_r.meter;
    assign o_tape_src = st_r.tape;
    assign o_ch_led_yellow = st_r.ch_y;
    assign o_rtn_led_green = st_r.rtn_g;
    assign o_rtn_led_red = st_r.rtn_r;
    assign o_rtn_led_yellow = st_r.rtn_y;
    assign o_gain_sel = st_r.gain_sel;
    assign o_gain_step = st_r.gain_step;
    assign o_gain_up = st_r.gain_up;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    AST_SOLO_TAP_LATCH: assert property ((g_tap[0] && !st_r.sol_lat[0] && g_tap[4:1] == 4'h0)
        |=> st_r.sol_lat == 5'h01 ##1 o_ch_led_yellow[4:1] == 4'h0)
        else $error("solo tap did not latch");
    AST_SOLO_ONEHOT: assert property ($onehot0(st_r.sol_lat))
        else $error("more than one latched solo");
    AST_SOLO_MOM_ALL: assert property (g_mom[4:0] != 5'h00
        |=> (o_solo_mask & $past(g_mom[4:0])) == $past(g_mom[4:0]))
        else $error("momentary solo dropped");
    AST_METER_SOLO: assert property (o_solo_mask != 5'h00 |-> o_meter_left_sel != 3'h0
        && o_solo_mask[o_meter_left_sel - 3'h1])
        else $error("left meter not on soloed channel");
    AST_LED_NO_SOLO: assert property (st_r.sol_lat == 5'h00 |=> o_ch_led_yellow == 5'h00)
        else $error("activity LED yellow without solo");
    AST_RTNA_OVERRIDE: assert property (rtn_on[0] |=> o_hp_l_src == hmr_pkg::SRC_RTNA_L
        && o_hp_r_src == hmr_pkg::SRC_RTNA_R)
        else $error("return A not routed");
    AST_TC_BLOCKS_B: assert property (st_r.tc_en |=> o_hp_l_src != hmr_pkg::SRC_RTNB_L
        && o_tape_src != hmr_pkg::TAPE_RTNB)
        else $error("return B audio while time code enabled");
    AST_TAPE_DEFAULT: assert property (st_r.loop == hmr_pkg::LOOP_OFF
        |=> o_tape_src == hmr_pkg::TAPE_BUS)
        else $error("tape source not the buses");
    AST_SPLIT_AB_LED: assert property (st_r.split == hmr_pkg::SPLIT_AB
        |=> o_rtn_led_yellow == 2'b11)
        else $error("combined split LEDs not solid");
    AST_GAIN_RTN: assert property ((i_rtn_sw_a && !st_r.cons[0])
        |=> o_gain_sel == hmr_pkg::GAIN_RTNA)
        else $error("knob not on return A gain");
    AST_SELECTOR: assert property ((rtn_on == 2'b00 && st_r.split == hmr_pkg::SPLIT_OFF
        && solo_now == 5'h00 && st_r.hp_sel == hmr_pkg::SEL_MONO)
        |=> o_hp_l_src == hmr_pkg::SRC_PGM_MONO)
        else $error("selector not followed");

    COV_SOLO_LATCH: cover property ($rose(st_r.sol_lat[2]));
    COV_SPLIT_AB: cover property (st_r.split == hmr_pkg::SPLIT_AB);
    COV_LOOP_B: cover property (o_tape_src == hmr_pkg::TAPE_RTNB);
endmodule : hmr_top

// File: bench/hmr_panel.sv
/* Front panel model: switch, knob, modifier levels and return activity.
   Assumes one bench process calls set, right after a clock edge. */
`timescale 1ns/1ps
module hmr_panel (
    input wire logic i_core_clk,
    output logic [10:0] o_panel
);
    initial o_panel = '0;
    // new levels stand for n cycles
    task automatic set(input logic [10:0] m, input int n);
        o_panel <= m;
        repeat (n) @(posedge i_core_clk);
    endtask : set
endmodule : hmr_panel

// File: bench/testbench.sv
/* Self-checking bench for hmr_top with short hold and blink counts.
   Assumes the panel model holds every switch level. */
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] rd;
    logic [31:0] hrdata;
    logic hrdy;
    wire [10:0] pnl;
    logic [3:0] hp_l, hp_r;
    logic [4:0] solo, chy;
    logic [2:0] meter;
    logic [1:0] tape, grn, yel;
    logic [1:0] red, gsel;
    logic [1:0] clip = 2'h0;
    logic kstep = 1'b0;
    logic kup = 1'b0;
    logic gstep, gup;
    int rises = 0;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    hmr_panel i_panel (.i_core_clk(clk), .o_panel(pnl));
    hmr_top #(.P_HOLD_CYC(26'd20), .P_BLINK_CYC(26'd4)) i_dut (.i_core_clk(clk), .i_rst(rst),
        .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(),
        .i_solo_sw(pnl[4:0]), .i_rtn_sw_a(pnl[5]), .i_rtn_sw_b(pnl[6]), .i_knob_hold(pnl[10]),
        .i_knob_step(kstep), .i_knob_up(kup), .i_modifier_key(pnl[9]), .i_rtn_active(pnl[8:7]),
        .i_rtn_clip(clip), .o_hp_l_src(hp_l), .o_hp_r_src(hp_r), .o_solo_mask(solo),
        .o_meter_left_sel(meter), .o_tape_src(tape), .o_ch_led_yellow(chy),
        .o_rtn_led_green(grn), .o_rtn_led_red(red), .o_rtn_led_yellow(yel), .o_gain_sel(gsel),
        .o_gain_step(gstep), .o_gain_up(gup));
    task automatic tally_and_finish();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : bus
    // slide toward m for three cycles while hold stays, then settle
    task automatic tap(input logic [10:0] hold, input logic [10:0] m);
        i_panel.set(hold | m, 3);
        i_panel.set(hold, 6);
    endtask : tap
    // yellow seen on {return, channel} leds over two blink periods; rises counts return pulses
    task automatic flash(output logic [6:0] s);
        logic [1:0] p;
        s = '0;
        rises = 0;
        @(negedge clk);
        p = yel;
        repeat (64) begin
            @(negedge clk);
            s = s | {yel, chy};
            rises += $countones(yel & ~p);
            p = yel;
        end
        @(posedge clk);
    endtask : flash
    task automatic test_solo();
        logic [6:0] s;
        tap(0, 11'h001);
        chk("solo", 5'h01, solo);
        chk("tape", hmr_pkg::TAPE_BUS, tape);
        flash(s);
        chk("ch_led", 7'h01, s);
        tap(0, 11'h002);
        chk("solo", 5'h02, solo);
        chk("meter", 3'h2, meter);
        tap(0, 11'h002);
        i_panel.set(11'h00c, 30);
        chk("solo", 5'h0c, solo);
        i_panel.set(0, 6);
        chk("solo", 5'h00, solo);
        $display("test_solo done");
    endtask : test_solo
    task automatic test_rtn();
        tap(11'h080, 11'h020);
        chk("hp_l", hmr_pkg::SRC_RTNA_L, hp_l);
        chk("hp_r", hmr_pkg::SRC_RTNA_R, hp_r);
        chk("yel", 2'h1, yel);
        chk("grn", 2'h1, grn);
        tap(0, 11'h020);
        i_panel.set(11'h040, 30);
        chk("hp_l", hmr_pkg::SRC_RTNB_L, hp_l);
        i_panel.set(0, 6);
        chk("hp_l", hmr_pkg::SRC_PGM_L, hp_l);
        $display("test_rtn done");
    endtask : test_rtn
    // return A held past the hold time while the knob steps and return B clips
    task automatic test_gain();
        clip <= 2'h2;
        kup <= 1'b1;
        i_panel.set(11'h120, 24);
        kstep <= 1'b1;
        @(posedge clk);
        kstep <= 1'b0;
        @(negedge clk);
        chk("gain_sel", hmr_pkg::GAIN_RTNA, gsel);
        chk("gain_step", 1'b1, gstep);
        chk("gain_up", 1'b1, gup);
        chk("red", 2'h2, red);
        chk("grn", 2'h0, grn);
        @(posedge clk);
        clip <= 2'h0;
        kup <= 1'b0;
        @(negedge clk);
        chk("gain_step", 1'b0, gstep);
        @(posedge clk);
        i_panel.set(0, 5);
        chk("gain_sel", hmr_pkg::GAIN_HP, gsel);
        $display("test_gain done");
    endtask : test_gain
    task automatic test_modes();
        logic [6:0] s;
        tap(11'h200, 11'h020);
        i_panel.set(0, 2);
        chk("tape", hmr_pkg::TAPE_RTNA, tape);
        flash(s);
        chk("loop_led", 7'h20, s);
        chk("loop_pulses", 32'd2, rises);
        tap(11'h200, 11'h020);
        i_panel.set(0, 2);
        chk("tape", hmr_pkg::TAPE_BUS, tape);
        tap(11'h400, 11'h020);
        i_panel.set(0, 2);
        chk("hp_l", hmr_pkg::SRC_RTNA_MONO, hp_l);
        chk("hp_r", hmr_pkg::SRC_PGM_R, hp_r);
        flash(s);
        chk("split_led", 7'h20, s);
        chk("split_pulses", 32'd4, rises);
        tap(11'h400, 11'h020);
        i_panel.set(0, 2);
        bus(1'b1, 32'h0, 32'h8);
        bus(1'b0, 32'h0, 32'h0);
        chk("ctrl", 32'h1 << hmr_pkg::CTRL_TC_BIT, rd);
        tap(0, 11'h040);
        chk("hp_l", hmr_pkg::SRC_PGM_L, hp_l);
        bus(1'b0, 32'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, 32'h0, 32'h1);
        i_panel.set(0, 2);
        chk("hp_r", hmr_pkg::SRC_PGM_MONO, hp_r);
        $display("test_modes done");
    endtask : test_modes
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        test_solo();
        test_rtn();
        test_gain();
        test_modes();
        tally_and_finish();
    end
endmodule : testbench
